// ===== hdl/tx_offload_host.sv
// host side: builds tx_parameter_block words and pseudo-header preload
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module tx_offload_host
   import tx_offload_host_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [DATA_W-1:0] s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic      [1:0]        s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic      [DATA_W-1:0] s_rdata,
   output logic      [1:0]        s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   output logic                   blk_valid,
   input  wire logic              blk_ready,
   output logic      [7:0]        blk_addr,
   output logic      [DATA_W-1:0] blk_word
);
   typedef enum logic [2:0] {S_IDLE, S_SUM, S_ACT, S_OFS, S_PSUM} state_t;
   logic              rst_n, done_q, aw_hold_q, w_hold_q;
   logic              do_wr, start, blk_take;
   state_t            st_q;
   logic [CTL_W-1:0]  ctrl_q;
   logic [31:0]       ofs_q, src_q, dst_q, len_q;
   logic [15:0]       vlan_q, sum_word, psum, pseudo_len, seg_pay, pay, mss;
   logic [2:0]        err_q, cnt_q, chk;
   logic [MODE_W-1:0] mode_q, mode_d;
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0]        wstrb_q, ihl;
   logic [7:0]        ip_ofs, l4_ofs, l4_hdr;
   reset_release u_rst (
      .clk    (ref_clk),
      .arst_n (nrst),
      .srst_n (rst_n)
   );

   assign ip_ofs = ofs_q[7:0];
   assign l4_ofs = ofs_q[15:8];
   assign ihl    = ofs_q[19:16];
   assign l4_hdr = ofs_q[31:24];
   assign pay    = len_q[15:0];
   assign mss    = len_q[31:16];
   assign blk_take = blk_valid && blk_ready;
   function automatic logic [31:0] merge(input logic [31:0] old, nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign do_wr = aw_hold_q && w_hold_q && !s_bvalid;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         s_bvalid  <= 1'b0;
         s_bresp   <= RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_hold_q <= 1'b1;
            s_awready <= 1'b0;
            awaddr_q  <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_hold_q <= 1'b1;
            s_wready <= 1'b0;
            wdata_q  <= s_wdata;
            wstrb_q  <= s_wstrb;
         end
         if (do_wr) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            s_bvalid  <= 1'b1;
            if (awaddr_q == REG_CTRL || awaddr_q == REG_OFS ||
                awaddr_q == REG_SRC_IP || awaddr_q == REG_DST_IP ||
                awaddr_q == REG_LEN || awaddr_q == REG_CMD ||
                awaddr_q == REG_VLAN) begin
               s_bresp <= RESP_OKAY;
            end else begin
               s_bresp <= RESP_SLVERR;
            end
         end
         if (s_bvalid && s_bready) begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
         end
      end
   end

   // register writes; frame setup is frozen while a block is under way
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= '0;
         ofs_q  <= '0;
         src_q  <= '0;
         dst_q  <= '0;
         len_q  <= '0;
         vlan_q <= '0;
      end else if (do_wr && st_q == S_IDLE) begin
         if (awaddr_q == REG_CTRL) begin
            ctrl_q <= CTL_W'(merge(32'(ctrl_q), wdata_q, wstrb_q));
         end else if (awaddr_q == REG_OFS) begin
            ofs_q <= merge(ofs_q, wdata_q, wstrb_q);
         end else if (awaddr_q == REG_SRC_IP) begin
            src_q <= merge(src_q, wdata_q, wstrb_q);
         end else if (awaddr_q == REG_DST_IP) begin
            dst_q <= merge(dst_q, wdata_q, wstrb_q);
         end else if (awaddr_q == REG_LEN) begin
            len_q <= merge(len_q, wdata_q, wstrb_q);
         end else if (awaddr_q == REG_VLAN) begin
            vlan_q <= 16'(merge(32'(vlan_q), wdata_q, wstrb_q));
         end
      end
   end

   assign start = do_wr && awaddr_q == REG_CMD && wstrb_q[0] &&
                  wdata_q[CMD_START] && st_q == S_IDLE;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rresp   <= RESP_OKAY;
         if (s_araddr == REG_CTRL) begin
            s_rdata <= 32'(ctrl_q);
         end else if (s_araddr == REG_OFS) begin
            s_rdata <= ofs_q;
         end else if (s_araddr == REG_SRC_IP) begin
            s_rdata <= src_q;
         end else if (s_araddr == REG_DST_IP) begin
            s_rdata <= dst_q;
         end else if (s_araddr == REG_LEN) begin
            s_rdata <= len_q;
         end else if (s_araddr == REG_CMD) begin
            s_rdata <= '0;
         end else if (s_araddr == REG_STATUS) begin
            s_rdata <= 32'({err_q, done_q, st_q != S_IDLE});
         end else if (s_araddr == REG_PSUM) begin
            s_rdata <= 32'(psum);
         end else if (s_araddr == REG_VLAN) begin
            s_rdata <= 32'(vlan_q);
         end else begin
            s_rdata <= '0;
            s_rresp <= RESP_SLVERR;
         end
      end else if (s_rvalid && s_rready) begin
         s_rvalid  <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   always_comb begin
      chk = '0;
      // device may corrupt the frame silently, so refuse up front
      chk[0] = ctrl_q[CTL_IPV4] && ihl < IHL_MIN;
      chk[1] = ctrl_q[CTL_L4] &&
               l4_hdr < (ctrl_q[CTL_TCP] ? TCP_CS_END : UDP_CS_END);
      chk[2] = ctrl_q[CTL_L4] && !mode_d[CTL_HWP] && ip_ofs == 8'h00;
   end

   always_comb begin
      mode_d = ctrl_q[MODE_W-1:0];
      // parser cannot handle these frames: explicit offsets instead
      if (ctrl_q[CTL_SEC] || ctrl_q[CTL_TUNNEL]) begin
         mode_d[CTL_HWP] = 1'b0;
      end
   end

   // large send: first segment carries at most one mss of payload
   assign seg_pay = (ctrl_q[CTL_LSO] && pay > mss) ? mss : pay;
   assign pseudo_len = 16'(l4_hdr) + seg_pay;

   always_comb begin
      case (cnt_q)
         3'd0:    sum_word = src_q[31:16];
         3'd1:    sum_word = src_q[15:0];
         3'd2:    sum_word = dst_q[31:16];
         3'd3:    sum_word = dst_q[15:0];
         3'd4:    sum_word = {8'h00,
                              ctrl_q[CTL_TCP] ? PROTO_TCP : PROTO_UDP};
         default: sum_word = pseudo_len;
      endcase
   end

   // left uncomplemented: the device folds it in and inverts at the end
   ones_sum16 #(
      .W (16)
   ) u_sum (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .clr   (start),
      .add   (st_q == S_SUM),
      .word  (sum_word),
      .sum_q (psum)
   );

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= S_IDLE;
         cnt_q     <= '0;
         mode_q    <= '0;
         done_q    <= 1'b0;
         err_q     <= '0;
         blk_valid <= 1'b0;
         blk_addr  <= '0;
         blk_word  <= '0;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (start) begin
                  done_q <= 1'b0;
                  err_q  <= chk;
                  mode_q <= mode_d;
                  cnt_q  <= '0;
                  if (chk == '0) begin
                     st_q <= S_SUM;
                  end
               end
            end
            S_SUM: begin
               cnt_q <= cnt_q + 3'd1;
               if (cnt_q == 3'(PSEUDO_WORDS - 1)) begin
                  st_q      <= S_ACT;
                  blk_valid <= 1'b1;
                  blk_addr  <= BLK_ACT;
                  blk_word  <= 32'(mode_q) << ACT_SHIFT;
               end
            end
            S_ACT: begin
               if (blk_take) begin
                  st_q     <= S_OFS;
                  blk_addr <= BLK_OFS;
                  // offsets as software gave them, vlan bytes excluded
                  blk_word <= {l4_ofs, ip_ofs, vlan_q};
               end
            end
            S_OFS: begin
               if (blk_take) begin
                  st_q     <= S_PSUM;
                  blk_addr <= BLK_PSUM;
                  blk_word <= {16'h0000, psum};
               end
            end
            S_PSUM: begin
               if (blk_take) begin
                  st_q      <= S_IDLE;
                  blk_valid <= 1'b0;
                  done_q    <= 1'b1;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_sec_no_parse: assert property (
      blk_valid && blk_addr == BLK_ACT && blk_word[ACT_SHIFT + CTL_SEC]
      |-> !blk_word[ACT_SHIFT + CTL_HWP])
      else $error("parsing left on with security");
   a_tunnel_semi_auto: assert property (
      start && ctrl_q[CTL_TUNNEL] |=> !mode_q[CTL_HWP])
      else $error("tunnel frame with hardware parsing");
   a_ip_ofs_field: assert property (
      blk_valid && blk_addr == BLK_OFS |-> blk_word[23:16] == ip_ofs)
      else $error("ip offset field wrong");
   a_l4_ofs_field: assert property (
      blk_valid && blk_addr == BLK_OFS |-> blk_word[31:24] == l4_ofs)
      else $error("transport offset field wrong");
   a_vlan_no_shift: assert property (
      blk_valid && blk_addr == BLK_OFS && mode_q[CTL_VLAN]
      |-> blk_word[31:16] == ofs_q[15:0])
      else $error("offsets shifted by vlan");
   a_l4_needs_ip: assert property (
      blk_valid && blk_addr == BLK_ACT && mode_q[CTL_L4]
      && !mode_q[CTL_HWP] |-> ip_ofs != 8'h00)
      else $error("transport offset without ip offset");
   a_ihl_minimum: assert property (
      start && ctrl_q[CTL_IPV4] && ihl < IHL_MIN
      |=> st_q == S_IDLE && err_q[0])
      else $error("short ip header not refused");
   a_l4_reach_csum: assert property (
      blk_valid && blk_addr == BLK_ACT && mode_q[CTL_L4] && mode_q[CTL_TCP]
      |-> l4_hdr >= TCP_CS_END)
      else $error("transport header too short");
   a_six_words: assert property (
      $rose(st_q == S_SUM) |-> (st_q == S_SUM) [*6] ##1 st_q == S_ACT)
      else $error("pseudo sum not over six words");
   a_lso_first_seg: assert property (
      mode_q[CTL_LSO] && pay > mss && st_q == S_SUM
      |-> pseudo_len == 16'(l4_hdr) + mss)
      else $error("large send length not first segment");
   a_psum_word: assert property (
      blk_valid && blk_addr == BLK_PSUM |-> blk_word[15:0] == psum
      && $past(st_q) != S_IDLE)
      else $error("preload word differs from sum");
   a_blk_hold: assert property (
      blk_valid && !blk_ready |=> blk_valid && $stable(blk_word)
      && $stable(blk_addr))
      else $error("block word dropped before taken");

   c_block_sent: cover property (blk_take && blk_addr == BLK_PSUM);
   c_large_send: cover property (blk_take && blk_addr == BLK_ACT
      && blk_word[ACT_SHIFT + CTL_LSO]);
   c_refused: cover property (start ##1 err_q != '0);
   c_both_csum: cover property (blk_take && blk_addr == BLK_ACT
      && blk_word[ACT_SHIFT + CTL_IPV4] && blk_word[ACT_SHIFT + CTL_L4]);
endmodule

// ===== hdl/tx_offload_host_pkg.sv
// constants for the parameter-block host controller
package tx_offload_host_pkg;
   // software register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_OFS    = 8'h04;
   localparam logic [7:0] REG_SRC_IP = 8'h08;
   localparam logic [7:0] REG_DST_IP = 8'h0c;
   localparam logic [7:0] REG_LEN    = 8'h10;
   localparam logic [7:0] REG_CMD    = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_PSUM   = 8'h1c;
   localparam logic [7:0] REG_VLAN   = 8'h20;
   // ctrl register bits; bits 0..7 map onto offload_mode_bits
   localparam int CTL_IPV4   = 0;
   localparam int CTL_L4     = 1;
   localparam int CTL_LSO    = 2;
   localparam int CTL_VLAN   = 3;
   localparam int CTL_HWP    = 4;
   localparam int CTL_SEC    = 5;
   localparam int CTL_SCHED  = 6;
   localparam int CTL_TCP    = 7;
   localparam int CTL_TUNNEL = 8;
   localparam int MODE_W     = 8;
   localparam int CTL_W      = 9;
   // placement of offload_mode_bits in the block word at 10h
   localparam int ACT_SHIFT  = 16;
   // status bits
   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_E_IHL   = 2;
   localparam int ST_E_L4    = 3;
   localparam int ST_E_IPOFS = 4;
   localparam int CMD_START  = 0;
   // tx_parameter_block word addresses on the device side
   localparam logic [7:0] BLK_ACT  = 8'h10;
   localparam logic [7:0] BLK_OFS  = 8'h14;
   localparam logic [7:0] BLK_PSUM = 8'hfc;
   // header facts
   localparam logic [3:0]  IHL_MIN     = 4'h5;
   localparam logic [7:0]  TCP_CS_END  = 8'h12;
   localparam logic [7:0]  UDP_CS_END  = 8'h08;
   localparam logic [7:0]  PROTO_TCP   = 8'h06;
   localparam logic [7:0]  PROTO_UDP   = 8'h11;
   localparam int          PSEUDO_WORDS = 6;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// ===== hdl/reset_release.sv
// two-flop release of the asynchronous reset
`timescale 1ns/1ps
module reset_release (
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      srst_n
);
   logic meta_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= 1'b0;
         srst_n <= 1'b0;
      end else begin
         meta_q <= 1'b1;
         srst_n <= meta_q;
      end
   end
endmodule

// ===== hdl/ones_sum16.sv
// running one's complement sum with end-around carry
`timescale 1ns/1ps
module ones_sum16 #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic         add,
   input  wire logic [W-1:0] word,
   output logic      [W-1:0] sum_q
);
   logic [W:0]   wide;
   logic [W-1:0] folded;

   // one fold suffices: a carry can only follow a sum below all ones
   assign wide   = {1'b0, sum_q} + {1'b0, word};
   assign folded = wide[W-1:0] + {{(W-1){1'b0}}, wide[W]};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sum_q <= '0;
      end else if (clr) begin
         sum_q <= '0;
      end else if (add) begin
         sum_q <= folded;
      end
   end
endmodule

// ===== verification/tx_device_model.sv
// device-side model that takes parameter-block words
`timescale 1ns/1ps
module tx_device_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        stall,
   input  wire logic        blk_valid,
   input  wire logic [7:0]  blk_addr,
   input  wire logic [31:0] blk_word,
   output logic             blk_ready,
   output logic [31:0]      mode_q,
   output logic [31:0]      ofs_q,
   output logic [31:0]      psum_q,
   output logic [7:0]       words_q,
   output logic             order_err_q
);
   logic [1:0] idx_q;
   logic [7:0] want;
   always_comb begin
      case (idx_q)
         2'h0: want = 8'h10;
         2'h1: want = 8'h14;
         default: want = 8'hfc;
      endcase
   end
   // slow mode drops ready every other cycle so each word must stand
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         blk_ready <= 1'b0;
      else
         blk_ready <= stall ? ~blk_ready : 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         words_q     <= 8'h00;
         idx_q       <= 2'h0;
         order_err_q <= 1'b0;
         mode_q      <= 32'h0;
         ofs_q       <= 32'h0;
         psum_q      <= 32'h0;
      end else if (blk_valid && blk_ready) begin
         words_q <= words_q + 8'h01;
         idx_q   <= (idx_q == 2'h2) ? 2'h0 : idx_q + 2'h1;
         if (blk_addr !== want)
            order_err_q <= 1'b1;
         case (blk_addr)
            8'h10: mode_q <= blk_word;
            8'h14: ofs_q  <= blk_word;
            8'hfc: psum_q <= blk_word;
            default: order_err_q <= 1'b1;
         endcase
      end
   end
endmodule

// ===== verification/test_tx_offload_host.sv
// self-checking bench for the parameter-block host controller
`timescale 1ns/1ps
module test_tx_offload_host
   import tx_offload_host_pkg::*;
;
   logic        ref_clk, nrst, stall;
   logic [7:0]  s_awaddr, s_araddr, blk_addr, words_q;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic        s_arvalid, s_arready, s_rvalid, s_rready, blk_valid, blk_ready;
   logic [31:0] s_wdata, s_rdata, blk_word, mode_q, ofs_q, psum_q;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp;
   logic        order_err_q;
   int          failures, check_count, cycles;
   localparam logic [31:0] SRC = 32'hc0a8_0001;
   localparam logic [31:0] DST = 32'hc0a8_00fe;

   tx_offload_host #(.DATA_W(32), .ADDR_W(8)) tx_offload_host_i (
      .ref_clk(ref_clk), .nrst(nrst),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .blk_valid(blk_valid),
      .blk_ready(blk_ready), .blk_addr(blk_addr), .blk_word(blk_word));
   tx_device_model tx_device_model_i (
      .clk(ref_clk), .rst_n(nrst), .stall(stall), .blk_valid(blk_valid),
      .blk_addr(blk_addr), .blk_word(blk_word), .blk_ready(blk_ready),
      .mode_q(mode_q), .ofs_q(ofs_q), .psum_q(psum_q), .words_q(words_q),
      .order_err_q(order_err_q));

   always #5 ref_clk = ~ref_clk;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // a hang ends the run here instead of in the main sequence
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw_done, w_done, b_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      b_done = 1'b0;
      @(posedge ref_clk);
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      while (!b_done) begin
         @(posedge ref_clk);
         if (!aw_done && s_awready) begin
            s_awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && s_wready) begin
            s_wvalid <= 1'b0;
            w_done = 1'b1;
         end
         if (s_bvalid) begin
            r = s_bresp;
            s_bready <= 1'b0;
            b_done = 1'b1;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic a_done;
      a_done = 1'b0;
      @(posedge ref_clk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (!a_done && s_arready) begin
            s_arvalid <= 1'b0;
            a_done = 1'b1;
         end
         if (s_rvalid) begin
            d = s_rdata;
            r = s_rresp;
            s_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   function automatic logic [15:0] fold(input logic [15:0] acc, w);
      logic [16:0] t;
      t = {1'b0, acc} + {1'b0, w};
      return t[15:0] + {15'h0, t[16]};
   endfunction

   // start a frame; every config write lands while idle
   task automatic cfg(input logic [31:0] ctrl, ofs, len);
      wr(REG_CTRL, ctrl);
      wr(REG_OFS, ofs);
      wr(REG_SRC_IP, SRC);
      wr(REG_DST_IP, DST);
      wr(REG_LEN, len);
      wr(REG_VLAN, 32'h0000_0123);
      wr(REG_CMD, 32'h0000_0001);
   endtask

   task automatic run_ok(input string nm, input logic [31:0] ctrl, ofs, len,
                         input logic [7:0] mode, proto,
                         input logic [15:0] l4len, input logic slow);
      logic [31:0] v;
      logic [1:0]  r;
      logic [15:0] ps;
      logic [7:0]  w0;
      w0 = words_q;
      stall <= slow;
      cfg(ctrl, ofs, len);
      for (int i = 0; i < 40; i++) begin
         axi_rd(REG_STATUS, v, r);
         if (v[ST_DONE] === 1'b1)
            break;
      end
      ps = fold(fold(fold(fold(fold(SRC[31:16], SRC[15:0]), DST[31:16]),
                DST[15:0]), {8'h00, proto}), l4len);
      chk("status", v, 32'h0000_0002);
      chk("mode word", mode_q, {8'h00, mode, 16'h0000});
      chk("offset word", ofs_q, {ofs[15:8], ofs[7:0], 16'h0123});
      chk("preload word", psum_q, {16'h0, ps});
      axi_rd(REG_PSUM, v, r);
      chk("psum reg", v, {16'h0, ps});
      chk("words", {24'h0, 8'(words_q - w0)}, 32'h3);
      chk("order", {31'h0, order_err_q}, 32'h0);
      $display("test %s done", nm);
   endtask

   task automatic run_err(input string nm, input logic [31:0] ctrl, ofs,
                          input logic [31:0] st);
      logic [31:0] v;
      logic [1:0]  r;
      logic [7:0]  w0;
      w0 = words_q;
      cfg(ctrl, ofs, 32'h0000_0064);
      axi_rd(REG_STATUS, v, r);
      chk("error status", v, st);
      repeat (12) @(posedge ref_clk);
      chk("no words", {24'h0, 8'(words_q - w0)}, 32'h0);
      $display("test %s done", nm);
   endtask

   initial begin
      logic [31:0] v;
      logic [1:0]  r;
      ref_clk = 1'b0;
      nrst = 1'b0;
      stall = 1'b0;
      s_awaddr = 8'h00;
      s_araddr = 8'h00;
      s_awvalid = 1'b0;
      s_wvalid = 1'b0;
      s_bready = 1'b0;
      s_arvalid = 1'b0;
      s_rready = 1'b0;
      s_wdata = 32'h0;
      s_wstrb = 4'hf;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      axi_rd(REG_STATUS, v, r);
      chk("status reset", v, 32'h0);
      axi_rd(8'h40, v, r);
      chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      chk("unmapped rdata", v, 32'h0);
      axi_wr(8'h40, 32'h1234_5678, r);
      chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      axi_wr(REG_STATUS, 32'h0000_00ff, r);
      chk("read-only bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      axi_rd(REG_CMD, v, r);
      chk("cmd reads zero", v, 32'h0);
      $display("test registers done");
      run_ok("tcp", 32'h83, 32'h1405_220e, 32'h0000_0064, 8'h83,
             PROTO_TCP, 16'd120, 1'b0);
      run_ok("udp secure", 32'h33, 32'h0805_220e, 32'h0000_0010, 8'h23,
             PROTO_UDP, 16'd24, 1'b1);
      run_ok("large send", 32'hdf, 32'h1405_220e, 32'h0200_1000, 8'hdf,
             PROTO_TCP, 16'h0214, 1'b1);
      run_ok("tunnel udp", 32'h113, 32'h0805_2a16, 32'h0000_0000, 8'h03,
             PROTO_UDP, 16'd8, 1'b0);
      run_err("short ihl", 32'h01, 32'h1404_220e, 32'h4);
      run_err("short tcp", 32'h82, 32'h1105_220e, 32'h8);
      run_err("no ip ofs", 32'h82, 32'h1405_2200, 32'h10);
      print_verdict();
   end
endmodule
